// file: nv_host_pkg.sv
// Constants for the nonvolatile store and recall host controller
package nv_host_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int CMP_W  = 14;
   localparam int SEQ_LEN = 6;
   localparam logic [CMP_W-1:0] SEQ_A0 = 14'h0E38;
   localparam logic [CMP_W-1:0] SEQ_A1 = 14'h31C7;
   localparam logic [CMP_W-1:0] SEQ_A2 = 14'h03E0;
   localparam logic [CMP_W-1:0] SEQ_A3 = 14'h3C1F;
   localparam logic [CMP_W-1:0] SEQ_A4 = 14'h303F;
   localparam logic [CMP_W-1:0] CMD_STORE    = 14'h0FC0;
   localparam logic [CMP_W-1:0] CMD_RECALL   = 14'h0C63;
   localparam logic [CMP_W-1:0] CMD_AS_OFF   = 14'h0B45;
   localparam logic [CMP_W-1:0] CMD_AS_ON    = 14'h0B46;
   localparam logic [1:0] OP_READ   = 2'h0;
   localparam logic [1:0] OP_WRITE  = 2'h1;
   localparam logic [1:0] OP_CMD    = 2'h2;
   localparam logic [1:0] OP_HSTORE = 2'h3;
   localparam logic [2:0] CMD_SEL_STORE  = 3'h0;
   localparam logic [2:0] CMD_SEL_RECALL = 3'h1;
   localparam logic [2:0] CMD_SEL_AS_OFF = 3'h2;
   localparam logic [2:0] CMD_SEL_AS_ON  = 3'h3;
   localparam int CLK_NS = 10;
   localparam int ACCESS_NS = 50;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int STORE_REQ_DELAY_NS = 500;
   localparam int STORE_REQ_DELAY_CYC = (STORE_REQ_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int BUSY_TIMEOUT_US = 20000;
   localparam int BUSY_TIMEOUT_CYC = BUSY_TIMEOUT_US * 1000 / CLK_NS;
   localparam int RECALL_US = 200;
   localparam int RECALL_CYC = RECALL_US * 1000 / CLK_NS;
   typedef enum logic [2:0] {
      IDLE_S, ACC_S, GAP_S, HREQ_S, WAIT_S, RELEASE_S
   } state_type;
endpackage

// file: nv_store_recall_control.sv
// Host controller that drives the nonvolatile static memory pins
// Operation
// RL1: Pulling busy pin low makes the device store after the request delay.
// RL2: Device stores on hardware request only if written since last store/recall.
// RL3: Device holds busy pin low throughout any store.
// RL4: Writes in flight finish within delay; later writes blocked until pin high. The device model drops any access that sees the pin low.
// RL5: Without pending writes device leaves pin alone; host must release it.
// RL6: After store device stays deselected until busy pin returns high.
// RL7: Power-up recall holds busy pin low and blocks accesses.
// RL8: Commands are six reads, first five at the fixed prefix addresses.
// RL9: Sixth read at store address starts a software store.
// RL10: Sixth read at recall address starts a software recall.
// RL11: Sixth read at disable address turns automatic store off.
// RL12: Sixth read at enable address turns automatic store on.
// RL13: Any other access inside the sequence aborts it.
// RL14: Write enable stays high for all six command reads.
// RL15: Only the low 14 address bits are compared.
// RL16: Software store blocks all access until store time elapses.
// RL17: Software recall blocks access until recall time elapses.
// RL18: After changing automatic store, host follows with a store. The controller issues no store itself; the requester must send one.
// RL19: Automatic store is enabled by default.
// RL20: Supply loss with automatic store enabled starts a capacitor store.
// RL21: Software store runs whether or not a write occurred.
// RL22: Sequence restarts at step one after abort or completion.
module nv_store_recall_control
   import nv_host_pkg::*;
#(
   parameter int ACC_CYC    = ACCESS_CYC,
   parameter int DELAY_CYC  = STORE_REQ_DELAY_CYC,
   parameter int TIMEOUT    = BUSY_TIMEOUT_CYC,
   parameter int RECALL_TO  = RECALL_CYC
) (
   // Clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          rst_b,
   input  wire logic                          clk_en,
   // User request
   input  wire logic                          req_valid,
   input  wire logic [1:0]                    req_op,
   input  wire logic [nv_host_pkg::ADDR_W-1:0] req_addr,
   input  wire logic [nv_host_pkg::DATA_W-1:0] req_wdata,
   input  wire logic [2:0]                    req_cmd,
   output logic                               req_ready,
   output logic                               rsp_valid,
   output logic [nv_host_pkg::DATA_W-1:0]     rsp_rdata,
   output logic                               rsp_timeout,
   // Memory pins
   output logic                               mem_ce_b,
   output logic                               mem_oe_b,
   output logic                               mem_we_b,
   output logic [nv_host_pkg::ADDR_W-1:0]     mem_addr,
   output logic [nv_host_pkg::DATA_W-1:0]     mem_dq_out,
   output logic                               mem_dq_oe,
   input  wire logic [nv_host_pkg::DATA_W-1:0] mem_dq_in,
   // Store busy pin, open drain
   output logic                               store_busy_pin_out,
   output logic                               store_busy_pin_oe,
   input  wire logic                          store_busy_pin_in,
   // Status
   output logic                               autostore_on
);
   import nv_host_pkg::*;

   function automatic logic [CMP_W-1:0] seq_addr(input logic [2:0] step,
                                                 input logic [2:0] cmd);
      logic [CMP_W-1:0] a;
      a = SEQ_A0;
      case (step)
         3'h0: a = SEQ_A0;
         3'h1: a = SEQ_A1;
         3'h2: a = SEQ_A2;
         3'h3: a = SEQ_A3;
         3'h4: a = SEQ_A4;
         default: begin
            case (cmd)
               CMD_SEL_RECALL: a = CMD_RECALL;
               CMD_SEL_AS_OFF: a = CMD_AS_OFF;
               CMD_SEL_AS_ON:  a = CMD_AS_ON;
               default:        a = CMD_STORE;
            endcase
         end
      endcase
      return a;
   endfunction

   state_type         state, next_state;
   logic [31:0]       cnt, next_cnt;
   logic [2:0]        step, next_step;
   logic [1:0]        op, next_op;
   logic [2:0]        cmd, next_cmd;
   logic              next_req_ready, next_rsp_valid, next_rsp_timeout;
   logic [DATA_W-1:0] next_rsp_rdata;
   logic              next_ce_b, next_oe_b, next_we_b, next_dq_oe, next_busy_oe;
   logic [ADDR_W-1:0] next_addr;
   logic [DATA_W-1:0] next_dq_out;
   logic              next_autostore_on;

   always_comb begin
      next_state       = state;
      next_cnt         = cnt;
      next_step        = step;
      next_op          = op;
      next_cmd         = cmd;
      next_req_ready   = 1'b0;
      next_rsp_valid   = 1'b0;
      next_rsp_rdata   = rsp_rdata;
      next_rsp_timeout = rsp_timeout;
      next_ce_b        = mem_ce_b;
      next_oe_b        = mem_oe_b;
      next_we_b        = mem_we_b;
      next_addr        = mem_addr;
      next_dq_out      = mem_dq_out;
      next_dq_oe       = mem_dq_oe;
      next_busy_oe     = store_busy_pin_oe;
      // Tracks the device setting that decides whether a supply loss stores [RL20]
      next_autostore_on = autostore_on;
      case (state)
         IDLE_S: begin
            // Busy low means recall or store under way; no access [RL7] [RL5]
            if (req_valid && req_ready && store_busy_pin_in) begin
               next_op          = req_op;
               next_cmd         = req_cmd;
               next_rsp_timeout = 1'b0;
               next_cnt         = 32'h0;
               next_step        = 3'h0;
               if (req_op == OP_HSTORE) begin
                  next_busy_oe = 1'b1;                  // [RL1]
                  next_state   = HREQ_S;
               end else begin
                  next_ce_b  = 1'b0;
                  // Write enable high for every command read [RL14]
                  next_we_b  = (req_op != OP_WRITE);
                  next_oe_b  = (req_op == OP_WRITE);
                  next_dq_oe = (req_op == OP_WRITE);
                  next_dq_out = req_wdata;
                  // Top address bit held low in commands [RL15]
                  next_addr  = (req_op == OP_CMD) ?
                               {1'b0, seq_addr(3'h0, req_cmd)} : req_addr;
                  next_state = ACC_S;
               end
            end else begin
               next_req_ready = store_busy_pin_in && !req_valid;
               if (store_busy_pin_in && req_valid && !req_ready)
                  next_req_ready = 1'b1;
            end
         end
         ACC_S: begin
            next_cnt = cnt + 32'h1;
            if (cnt >= 32'(ACC_CYC - 1)) begin
               next_rsp_rdata = mem_dq_in;
               next_ce_b  = 1'b1;
               next_oe_b  = 1'b1;
               next_we_b  = 1'b1;
               next_dq_oe = 1'b0;
               next_cnt   = 32'h0;
               next_state = GAP_S;
            end
         end
         GAP_S: begin
            // Six back-to-back reads with nothing between them [RL8] [RL13]
            if (op == OP_CMD && step < 3'(SEQ_LEN - 1)) begin
               next_step  = step + 3'h1;
               next_ce_b  = 1'b0;
               next_oe_b  = 1'b0;
               next_addr  = {1'b0, seq_addr(step + 3'h1, cmd)};
               next_state = ACC_S;
            end else if (op == OP_CMD &&
                         (cmd == CMD_SEL_STORE || cmd == CMD_SEL_RECALL)) begin
               next_state = WAIT_S;                     // [RL9] [RL10] [RL21]
            end else begin
               if (op == OP_CMD && cmd == CMD_SEL_AS_OFF)
                  next_autostore_on = 1'b0;             // [RL11]
               if (op == OP_CMD && cmd == CMD_SEL_AS_ON)
                  next_autostore_on = 1'b1;             // [RL12]
               next_rsp_valid = 1'b1;
               next_step      = 3'h0;                   // [RL22]
               next_state     = IDLE_S;
            end
         end
         HREQ_S: begin
            // Give the device the request delay before releasing [RL4] [RL2]
            next_cnt = cnt + 32'h1;
            if (cnt >= 32'(DELAY_CYC)) begin
               next_busy_oe = 1'b0;                     // [RL5]
               next_cnt     = 32'h0;
               next_state   = WAIT_S;
            end
         end
         WAIT_S: begin
            // Device owns busy pin until store or recall ends [RL3] [RL16] [RL17]
            next_cnt = cnt + 32'h1;
            if (store_busy_pin_in && cnt > 32'h1) begin
               next_state = RELEASE_S;
            end else if (cnt >= 32'(TIMEOUT)) begin
               next_rsp_timeout = 1'b1;
               next_state       = RELEASE_S;
            end
         end
         RELEASE_S: begin
            // Stay off the bus until pin seen high or the timeout flag is set [RL6]
            if (store_busy_pin_in || rsp_timeout) begin
               next_rsp_valid = 1'b1;
               next_step      = 3'h0;
               next_cnt       = 32'h0;
               next_state     = IDLE_S;
            end
         end
         default: next_state = IDLE_S;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state       <= IDLE_S;
         cnt         <= 32'h0;
         step        <= 3'h0;
         op          <= OP_READ;
         cmd         <= CMD_SEL_STORE;
         req_ready   <= 1'b0;
         rsp_valid   <= 1'b0;
         rsp_rdata   <= 8'h00;
         rsp_timeout <= 1'b0;
         mem_ce_b    <= 1'b1;
         mem_oe_b    <= 1'b1;
         mem_we_b    <= 1'b1;
         mem_addr    <= 15'h0000;
         mem_dq_out  <= 8'h00;
         mem_dq_oe   <= 1'b0;
         store_busy_pin_oe <= 1'b0;
         autostore_on <= 1'b1;                          // [RL19]
      end else if (clk_en) begin
         state       <= next_state;
         cnt         <= next_cnt;
         step        <= next_step;
         op          <= next_op;
         cmd         <= next_cmd;
         req_ready   <= next_req_ready;
         rsp_valid   <= next_rsp_valid;
         rsp_rdata   <= next_rsp_rdata;
         rsp_timeout <= next_rsp_timeout;
         mem_ce_b    <= next_ce_b;
         mem_oe_b    <= next_oe_b;
         mem_we_b    <= next_we_b;
         mem_addr    <= next_addr;
         mem_dq_out  <= next_dq_out;
         mem_dq_oe   <= next_dq_oe;
         store_busy_pin_oe <= next_busy_oe;
         autostore_on <= next_autostore_on;
      end
   end

   // Open drain: only ever drives low
   assign store_busy_pin_out = 1'b0;

   a_cmd_we_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (op == OP_CMD && !mem_ce_b && state == ACC_S) |-> mem_we_b)   // [RL14]
      else $error("write enable low during command read");
   a_addr_top_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (op == OP_CMD && state == ACC_S) |-> !mem_addr[ADDR_W-1])     // [RL15]
      else $error("top address bit set in command");
   a_no_access_busy: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (state == WAIT_S || state == RELEASE_S) |-> mem_ce_b)         // [RL6]
      else $error("chip selected while busy");
   a_hreq_release: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(store_busy_pin_oe) |=> store_busy_pin_oe[*2])           // [RL1]
      else $error("store request pulse too short");
   a_as_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (clk_en && state == GAP_S && op == OP_CMD && step == 3'h5
       && cmd == CMD_SEL_AS_OFF) |=> !autostore_on)                 // [RL11]
      else $error("automatic store not disabled");
   a_as_on: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (clk_en && state == GAP_S && op == OP_CMD && step == 3'h5
       && cmd == CMD_SEL_AS_ON) |=> autostore_on)                   // [RL12]
      else $error("automatic store not enabled");
   a_seq_restart: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (clk_en && rsp_valid) |-> step == 3'h0)                       // [RL22]
      else $error("sequence step not cleared");
   a_od_never_high: assert property (@(posedge ref_clk) disable iff (!rst_b)
      store_busy_pin_oe |-> !store_busy_pin_out)                    // [RL3]
      else $error("busy pin driven high");
   c_store_cmd: cover property (@(posedge ref_clk) disable iff (!rst_b)
      state == WAIT_S && op == OP_CMD);
   c_hw_store: cover property (@(posedge ref_clk) disable iff (!rst_b)
      state == HREQ_S);
   c_timeout: cover property (@(posedge ref_clk) disable iff (!rst_b)
      rsp_timeout);
endmodule

// file: nv_dev_model.sv
// Behavioural model of the nonvolatile static memory device
module nv_dev_model
   import nv_host_pkg::*;
#(
   parameter int HOLD   = 8,
   parameter int ST_CYC = 100,
   parameter int RC_CYC = 60
) (
   // Timing reference only
   input  wire logic        ref_clk,
   // Memory pins
   input  wire logic        ce_b,
   input  wire logic        oe_b,
   input  wire logic        we_b,
   input  wire logic [14:0] addr,
   input  wire logic [7:0]  dq_host,
   output logic [7:0]       dq_dev,
   // Busy pin, resolved level and own pull-down
   input  wire logic        busy_pin,
   output logic             busy_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [13:0] PFX [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
   logic [7:0]  mem [32768];
   logic [7:0]  nv [32768];
   logic [14:0] a;
   logic [7:0]  d;
   logic        w;
   logic        act = 1'b0;
   logic        ok = 1'b1;
   logic        tog = 1'b0;
   logic        dirty = 1'b0;
   logic        as_on = 1'b1;
   int          step = 0;
   int          low = 0;
   int          busy = 20; // Power-up recall
   int          stores = 0;
   int          recalls = 0;
   assign busy_oe = busy != 0;
   // Released bus toggles so stale data never passes for a read
   assign dq_dev = (!ce_b && !oe_b && we_b && busy_pin) ? mem[addr] : {8{tog}} ^ 8'hA5;
   always @(posedge ref_clk) begin
      tog <= !tog;
      if (busy != 0) busy <= busy - 1;
      low <= (!busy_pin && !busy_oe) ? low + 1 : 0;
      if (low == HOLD && dirty) begin
         busy <= ST_CYC;
         stores <= stores + 1;
         dirty <= 1'b0;
         nv = mem;
      end
      if (!ce_b) begin
         act <= 1'b1;
         ok <= ok && busy_pin; // Any access seeing the pin low is dropped
         a <= addr;
         d <= dq_host;
         w <= !we_b; // A read with write enable low counts as a write
      end else if (act) begin
         act <= 1'b0;
         ok <= 1'b1;
         if (ok && w) begin
            mem[a] = d;
            dirty <= 1'b1;
            step <= 0;
         end else if (ok && step < 5) begin
            step <= (a[13:0] == PFX[step]) ? step + 1 : int'(a[13:0] == PFX[0]);
         end else if (ok) begin
            step <= int'(a[13:0] == PFX[0]);
            case (a[13:0])
               CMD_STORE: begin
                  busy <= ST_CYC;
                  stores <= stores + 1;
                  dirty <= 1'b0;
                  nv = mem;
               end
               CMD_RECALL: begin
                  busy <= RC_CYC;
                  recalls <= recalls + 1;
                  dirty <= 1'b0;
                  mem = nv;
               end
               CMD_AS_OFF: as_on <= 1'b0;
               CMD_AS_ON: as_on <= 1'b1;
               default: ;
            endcase
         end
      end
   end
endmodule

// file: tb_top.sv
// Self-checking testbench for the store and recall host controller
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import nv_host_pkg::*;
   localparam int ACC = 5;
   localparam int LIM = 1000;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        req_valid = 1'b0;
   logic [1:0]  req_op = 2'h0;
   logic [14:0] req_addr = 15'h0000;
   logic [7:0]  req_wdata = 8'h00;
   logic [2:0]  req_cmd = 3'h0;
   logic        req_ready, rsp_valid, rsp_timeout, autostore_on;
   logic        mem_ce_b, mem_oe_b, mem_we_b, mem_dq_oe, host_oe, dev_oe;
   logic [14:0] mem_addr;
   logic [7:0]  rsp_rdata, mem_dq_out, mem_dq_in;
   wire logic   busy_pin = !(host_oe || dev_oe); // Pull-up when nobody pulls
   wire logic [7:0] dq_w = mem_dq_oe ? mem_dq_out : ~mem_dq_in;
   int          errors = 0;
   int          tests_run = 0;
   int          lat;
   always #5 ref_clk = !ref_clk;
   nv_store_recall_control #(.DELAY_CYC(10), .TIMEOUT(300)) i_nv_store_recall_control (
      .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .req_valid(req_valid),
      .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_cmd(req_cmd),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .rsp_timeout(rsp_timeout), .mem_ce_b(mem_ce_b), .mem_oe_b(mem_oe_b),
      .mem_we_b(mem_we_b), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out),
      .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in), .store_busy_pin_out(),
      .store_busy_pin_oe(host_oe), .store_busy_pin_in(busy_pin), .autostore_on(autostore_on));
   nv_dev_model i_nv_dev_model (.ref_clk(ref_clk), .ce_b(mem_ce_b), .oe_b(mem_oe_b),
      .we_b(mem_we_b), .addr(mem_addr), .dq_host(dq_w), .dq_dev(mem_dq_in),
      .busy_pin(busy_pin), .busy_oe(dev_oe));
   task automatic final_report();
      if (errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("mismatch at %0t: got %0h expected %0h", $time, s, e);
      end
   endtask
   task automatic req(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d,
                      input logic [2:0] c);
      logic rdy;
      rdy = 1'b0;
      lat = 0;
      @(posedge ref_clk);
      req_op <= op;
      req_addr <= a;
      req_wdata <= d;
      req_cmd <= c;
      req_valid <= 1'b1;
      while (!rdy) begin
         @(negedge ref_clk);
         rdy = (req_ready === 1'b1) && (busy_pin === 1'b1);
         @(posedge ref_clk);
         lat++;
         if (lat > LIM) begin
            errors++;
            final_report();
         end
      end
      req_valid <= 1'b0;
      lat = 0;
      do begin
         @(negedge ref_clk);
         lat++;
         if (lat > LIM) begin
            errors++;
            final_report();
         end
      end while (rsp_valid !== 1'b1);
   endtask
   task automatic t_boot();
      @(negedge ref_clk);
      chk(busy_pin, 1'b0);
      chk(req_ready, 1'b0);
      chk(autostore_on, 1'b1);
      chk(i_nv_dev_model.as_on, 1'b1);
      // Power-up recall still running here, so the host must stay off the bus
      repeat (10) begin
         @(negedge ref_clk);
         chk(busy_pin, 1'b0);
         chk(req_ready, 1'b0);
      end
   endtask
   task automatic t_hclean();
      req(OP_HSTORE, 15'h0000, 8'h00, 3'h0);
      chk(i_nv_dev_model.stores, 0);
      chk(lat < 100, 1'b1);
      chk(rsp_timeout, 1'b0);
   endtask
   task automatic t_rw();
      req(OP_WRITE, 15'h5234, 8'hA5, 3'h0);
      chk(lat, ACC + 2);
      chk(i_nv_dev_model.mem[15'h5234], 8'hA5);
      req(OP_READ, 15'h5234, 8'h00, 3'h0);
      chk(rsp_rdata, 8'hA5);
   endtask
   task automatic t_hstore();
      req(OP_HSTORE, 15'h0000, 8'h00, 3'h0);
      chk(i_nv_dev_model.stores, 1);
      chk(lat > 100, 1'b1);
      chk(rsp_timeout, 1'b0);
   endtask
   task automatic t_cmds();
      req(OP_CMD, 15'h0000, 8'h00, CMD_SEL_STORE);
      chk(i_nv_dev_model.stores, 2);
      chk(lat > 100, 1'b1);
      req(OP_WRITE, 15'h5234, 8'h3C, 3'h0);
      req(OP_CMD, 15'h0000, 8'h00, CMD_SEL_RECALL);
      chk(i_nv_dev_model.recalls, 1);
      chk(lat > 60, 1'b1);
      req(OP_READ, 15'h5234, 8'h00, 3'h0);
      chk(rsp_rdata, 8'hA5);
      req(OP_CMD, 15'h0000, 8'h00, CMD_SEL_AS_OFF);
      chk(lat, 6 * (ACC + 1) + 1);
      chk(autostore_on, 1'b0);
      chk(i_nv_dev_model.as_on, 1'b0);
      req(OP_CMD, 15'h0000, 8'h00, CMD_SEL_STORE); // Setting saved
      req(OP_CMD, 15'h0000, 8'h00, CMD_SEL_AS_ON);
      chk(autostore_on, 1'b1);
      chk(i_nv_dev_model.as_on, 1'b1);
      chk(i_nv_dev_model.stores, 3);
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_boot();
      t_hclean();
      t_rw();
      t_hstore();
      t_cmds();
      final_report();
   end
endmodule
